// File: rtl/sfp_defines.vh
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

// ==================================================================
// Opcodes
`define SFP_OP_WRITE_ENABLE_CMD       8'h06
`define SFP_OP_WRDI       8'h04
`define SFP_OP_RDSR       8'h05
`define SFP_OP_PP         8'h02
`define SFP_OP_QPP        8'h33
`define SFP_OP_SE         8'h20
`define SFP_OP_BE32       8'h52
`define SFP_OP_BE64       8'hd8
`define SFP_OP_CE1        8'hc7
`define SFP_OP_CE2        8'h60
`define SFP_OP_SUSP       8'h75
`define SFP_OP_RESM       8'h7a

// ==================================================================
// Status byte bit positions
`define SFP_ST_BUSY       0
`define SFP_ST_WEL        1
`define SFP_ST_SUS        7

// ==================================================================
// Operation kinds
`define SFP_K_PP          3'h0
`define SFP_K_SE          3'h1
`define SFP_K_BE32        3'h2
`define SFP_K_BE64        3'h3
`define SFP_K_CE          3'h4

// ==================================================================
// Timing
`define SFP_CLK_MHZ       10
`define SFP_PP_TIME_US    600
`define SFP_SE_TIME_US    60000
`define SFP_BE32_TIME_US  200000
`define SFP_BE64_TIME_US  350000
`define SFP_CE_TIME_US    2000000
`define SFP_SUS_TIME_US   20
`define SFP_RES_TIME_NS   200

// ==================================================================
// Buffering
`define SFP_FIFO_WIDTH    32
`define SFP_FIFO_DEPTH    32

`endif

// File: rtl/sfp_core.v
// Summary of operation
// - Page program is 02h, 24-bit address, data bytes; needs latch set.
// - Write enable command sets the write enable latch.
// - Data address wraps within the 256-byte page; late bytes overwrite.
// - Partial page program leaves untouched bytes of the page unchanged.
// - Chip select must rise on a byte boundary, else command discarded.
// - Chip select rise starts timed cycle; busy is 1 until it ends.
// - Read status stays serviced during program and erase cycles.
// - Write enable latch clears when busy sets at cycle start, not on resume.
// - Quad program 33h needs quad enable and latch; data on four lines.
// - Sector erase 20h with address erases the 4K sector, timed.
// - Half block erase 52h with address erases the 32K block, timed.
// - Block erase D8h with address erases the 64K block, timed.
// - Chip erase C7h or 60h, no address, erases the whole array.
// - Program only drives bits toward 0; erase returns them to 1.
// - Suspend 75h accepted only when not suspended and busy, else ignored.
// - Accepted suspend sets suspend flag at once, busy clears within latency.
// - Suspend is ignored during chip erase.
// - While erase suspended, status writes and erase opcodes are refused.
// - While program suspended, program opcodes are refused as well.
// - Reset while suspended ends suspension and clears the suspend flag.
// - Resume 7Ah only when suspended and idle; flag clears, busy sets fast.
`timescale 1ns/1ns
`default_nettype none
`include "sfp_defines.vh"

// ==================================================================
// Program data FIFO with registered head
module sfp_fifo #(
    parameter WIDTH = `SFP_FIFO_WIDTH,
    parameter DEPTH = `SFP_FIFO_DEPTH,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output reg              out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data,
    // State
    output wire             idle
);
    // Depth must be a power of two for pointer wrap
    localparam [AW:0] FULL = DEPTH;
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wptr;
    reg  [AW-1:0]    rptr;
    reg  [AW:0]      cnt;
    wire             push;
    wire             pop;

    assign in_ready = (cnt != FULL);
    assign push     = in_valid & in_ready;
    assign pop      = (cnt != {(AW+1){1'b0}}) & (~out_valid | out_ready);
    assign idle     = (cnt == {(AW+1){1'b0}}) & ~out_valid;

    always @(posedge ref_clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wptr      <= {AW{1'b0}};
            rptr      <= {AW{1'b0}};
            cnt       <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                out_data  <= mem[rptr];
                rptr      <= rptr + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push & ~pop) begin
                cnt <= cnt + 1'b1;
            end else if (pop & ~push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule

// ==================================================================
// Program / erase / suspend sequencer
module sfp_core #(
    parameter [31:0] PP_CYC   = `SFP_PP_TIME_US * `SFP_CLK_MHZ,
    parameter [31:0] SE_CYC   = `SFP_SE_TIME_US * `SFP_CLK_MHZ,
    parameter [31:0] BE32_CYC = `SFP_BE32_TIME_US * `SFP_CLK_MHZ,
    parameter [31:0] BE64_CYC = `SFP_BE64_TIME_US * `SFP_CLK_MHZ,
    parameter [31:0] CE_CYC   = `SFP_CE_TIME_US * `SFP_CLK_MHZ,
    parameter [31:0] SUS_CYC  = `SFP_SUS_TIME_US * `SFP_CLK_MHZ
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // Serial link pins
    input  wire        sck,
    input  wire        cs_n,
    input  wire [3:0]  io_in,
    output reg  [3:0]  io_out,
    output reg  [3:0]  io_oe,
    // Configuration and status
    input  wire        quad_enable_bit,
    output reg         busy,
    output reg         write_enable_latch,
    output reg         suspend_flag,
    // Array program port
    output wire        mem_valid,
    input  wire        mem_ready,
    output wire [23:0] mem_addr,
    output wire [7:0]  mem_data,
    // Array erase port
    output reg         erase_valid,
    output reg  [2:0]  erase_kind,
    output reg  [23:0] erase_addr
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_RUN  = 4'b0010;
    localparam [3:0] ST_SUSW = 4'b0100;
    localparam [3:0] ST_SUSP = 4'b1000;

    // ==============================================================
    // Pin synchronisers
    reg        sck_s1;
    reg        sck_s2;
    reg        sck_s3;
    reg        cs_s1;
    reg        cs_s2;
    reg        cs_s3;
    reg  [3:0] io_s1;
    reg  [3:0] io_s2;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            cs_s3  <= 1'b1;
            io_s1  <= 4'h0;
            io_s2  <= 4'h0;
        end else begin
            sck_s1 <= sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            cs_s1  <= cs_n;
            cs_s2  <= cs_s1;
            cs_s3  <= cs_s2;
            io_s1  <= io_in;
            io_s2  <= io_s1;
        end
    end

    wire sel     = ~cs_s2;
    wire rise    = sel & sck_s2 & ~sck_s3;
    wire fall    = sel & ~sck_s2 & sck_s3;
    wire cs_rise = cs_s2 & ~cs_s3;

    // ==============================================================
    // Byte assembly
    reg  [7:0]  shreg;
    reg  [2:0]  bitcnt;
    reg  [2:0]  bytecnt;
    reg  [7:0]  opcode;
    reg         quad_ph;
    reg  [23:0] addr;
    reg  [7:0]  addr_lo;
    reg         rd_active;
    reg  [2:0]  fbit;
    reg  [7:0]  pbuf [0:255];
    reg  [255:0] pmask;
    reg  [3:0]  state;
    reg  [2:0]  kind;
    reg  [31:0] tmr;
    reg  [31:0] target;
    reg  [8:0]  widx;
    reg  [7:0]  next_sh;
    reg  [2:0]  next_bitcnt;
    reg         byte_done;

    wire is_prog  = (opcode == `SFP_OP_PP) | (opcode == `SFP_OP_QPP);
    wire buf_open = (state == ST_IDLE);
    wire [7:0] status_live = {suspend_flag, 5'h00, write_enable_latch, busy};
    // Data phase write into page buffer; address byte 3 seeds the column
    wire pbuf_we = rise & byte_done & (bytecnt >= 3'h4) & is_prog & buf_open;

    always @* begin
        next_sh     = quad_ph ? {shreg[3:0], io_s2} : {shreg[6:0], io_s2[0]};
        next_bitcnt = quad_ph ? bitcnt + 3'h4 : bitcnt + 3'h1;
        byte_done   = quad_ph ? bitcnt[2] : (bitcnt == 3'h7);
    end

    always @(posedge ref_clk) begin
        if (pbuf_we) begin
            pbuf[addr_lo] <= next_sh;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            shreg     <= 8'h00;
            bitcnt    <= 3'h0;
            bytecnt   <= 3'h0;
            opcode    <= 8'h00;
            quad_ph   <= 1'b0;
            addr      <= 24'h000000;
            addr_lo   <= 8'h00;
            rd_active <= 1'b0;
            fbit      <= 3'h0;
            pmask     <= {256{1'b0}};
            io_out    <= 4'h0;
            io_oe     <= 4'h0;
        end else if (!sel) begin
            // Deselect resets framing; a partial byte is simply dropped
            bitcnt    <= 3'h0;
            bytecnt   <= 3'h0;
            quad_ph   <= 1'b0;
            rd_active <= 1'b0;
            io_oe     <= 4'h0;
        end else begin
            if (rise) begin
                shreg  <= next_sh;
                bitcnt <= next_bitcnt;
                if (byte_done) begin
                    if (bytecnt != 3'h5) begin
                        bytecnt <= bytecnt + 3'h1;
                    end
                    if (bytecnt == 3'h0) begin
                        opcode <= next_sh;
                        // Quad lines only when enabled
                        quad_ph <= (next_sh == `SFP_OP_QPP) & quad_enable_bit;
                        // Status stays readable in every state
                        rd_active <= (next_sh == `SFP_OP_RDSR);
                        fbit      <= 3'h0;
                        if (((next_sh == `SFP_OP_PP) | (next_sh == `SFP_OP_QPP)) & buf_open) begin
                            pmask <= {256{1'b0}};
                        end
                    end else if (bytecnt <= 3'h3) begin
                        addr <= {addr[15:0], next_sh};
                        if (bytecnt == 3'h3) begin
                            addr_lo <= next_sh;
                        end
                    end else if (is_prog & buf_open) begin
                        // Column wraps inside the page by 8-bit overflow
                        pmask[addr_lo] <= 1'b1;
                        addr_lo        <= addr_lo + 8'h01;
                    end
                end
            end
            if (fall & rd_active) begin
                // Live status, so busy polling sees each change
                io_out[1] <= status_live[~fbit];
                io_oe[1]  <= 1'b1;
                fbit      <= fbit + 3'h1;
            end
        end
    end

    // ==============================================================
    // Command execution at chip select rise
    wire aligned  = (bitcnt == 3'h0);
    wire one_byte = aligned & (bytecnt == 3'h1);
    wire adr_only = aligned & (bytecnt == 3'h4);
    wire has_data = aligned & (bytecnt == 3'h5);
    wire op_erase = (opcode == `SFP_OP_SE) | (opcode == `SFP_OP_BE32) |
                    (opcode == `SFP_OP_BE64);
    wire op_chip  = (opcode == `SFP_OP_CE1) | (opcode == `SFP_OP_CE2);
    // Opcodes 01h/31h have no effect here; refused while suspended
    // Idle-only start means suspended states refuse program and erase
    wire can_start = (state == ST_IDLE) & write_enable_latch;
    wire go_pp   = can_start & has_data & ((opcode == `SFP_OP_PP) |
                   ((opcode == `SFP_OP_QPP) & quad_ph));
    wire go_er   = can_start & adr_only & op_erase;
    wire go_ce   = can_start & one_byte & op_chip;
    wire susp_ok = (state == ST_RUN) & (kind != `SFP_K_CE) & ~suspend_flag & busy;

    // FIFO feed from page buffer during the program cycle
    wire        walk_act = (state == ST_RUN) & (kind == `SFP_K_PP) & ~widx[8];
    wire        walk_hit = walk_act & pmask[widx[7:0]];
    wire        fifo_rdy;
    wire        fifo_idle;
    // Only received columns reach the array
    wire [31:0] fifo_din = {addr[23:8], widx[7:0], pbuf[widx[7:0]]};

    always @* begin
        case (kind)
            `SFP_K_PP:   target = PP_CYC;
            `SFP_K_SE:   target = SE_CYC;
            `SFP_K_BE32: target = BE32_CYC;
            `SFP_K_BE64: target = BE64_CYC;
            default:     target = CE_CYC;
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            // Reset ends any suspension
            state              <= ST_IDLE;
            suspend_flag       <= 1'b0;
            busy               <= 1'b0;
            write_enable_latch <= 1'b0;
            kind               <= `SFP_K_PP;
            tmr                <= 32'h00000000;
            widx               <= 9'h000;
            erase_valid        <= 1'b0;
            erase_kind         <= `SFP_K_PP;
            erase_addr         <= 24'h000000;
        end else begin
            erase_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cs_rise) begin
                        if (go_pp | go_er | go_ce) begin
                            // Timed cycle begins at chip select rise
                            state              <= ST_RUN;
                            busy               <= 1'b1;
                            write_enable_latch <= 1'b0;
                            tmr                <= 32'h00000000;
                            widx               <= 9'h000;
                        end else if (one_byte & (opcode == `SFP_OP_WRITE_ENABLE_CMD)) begin
                            write_enable_latch <= 1'b1;
                        end else if (one_byte & (opcode == `SFP_OP_WRDI)) begin
                            write_enable_latch <= 1'b0;
                        end
                        if (go_pp) begin
                            kind <= `SFP_K_PP;
                        end
                        if (go_er | go_ce) begin
                            // Erase port sets the region to all ones
                            erase_valid <= 1'b1;
                            erase_addr  <= go_ce ? 24'h000000 : addr;
                            if (go_ce) begin
                                kind       <= `SFP_K_CE;
                                erase_kind <= `SFP_K_CE;
                            end else if (opcode == `SFP_OP_SE) begin
                                kind       <= `SFP_K_SE;
                                erase_kind <= `SFP_K_SE;
                            end else if (opcode == `SFP_OP_BE32) begin
                                kind       <= `SFP_K_BE32;
                                erase_kind <= `SFP_K_BE32;
                            end else begin
                                kind       <= `SFP_K_BE64;
                                erase_kind <= `SFP_K_BE64;
                            end
                        end
                    end
                end
                ST_RUN: begin
                    if (cs_rise & one_byte & (opcode == `SFP_OP_SUSP) & susp_ok) begin
                        suspend_flag <= 1'b1;
                        state        <= ST_SUSW;
                        tmr          <= 32'h00000000;
                    end else begin
                        if (tmr != target) begin
                            tmr <= tmr + 32'h00000001;
                        end
                        if (walk_act & (~walk_hit | fifo_rdy)) begin
                            widx <= widx + 9'h001;
                        end
                        // Busy holds until time elapsed and data drained
                        if ((tmr == target) & ~walk_act & fifo_idle) begin
                            busy  <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                    if (cs_rise & one_byte & (opcode == `SFP_OP_WRITE_ENABLE_CMD)) begin
                        write_enable_latch <= 1'b1;
                    end
                end
                ST_SUSW: begin
                    // Elapsed time discarded, timer counts latency; busy drops at end of latency
                    if (tmr >= SUS_CYC - 32'h00000001) begin
                        busy  <= 1'b0;
                        state <= ST_SUSP;
                        tmr   <= 32'h00000000;
                    end else begin
                        tmr <= tmr + 32'h00000001;
                    end
                end
                ST_SUSP: begin
                    if (cs_rise & one_byte) begin
                        if (opcode == `SFP_OP_RESM) begin
                            // Elapsed time restarts from zero on resume
                            suspend_flag <= 1'b0;
                            busy         <= 1'b1;
                            state        <= ST_RUN;
                        end else if (opcode == `SFP_OP_WRITE_ENABLE_CMD) begin
                            write_enable_latch <= 1'b1;
                        end else if (opcode == `SFP_OP_WRDI) begin
                            write_enable_latch <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==============================================================
    // Program data path; array applies bytes as AND
    sfp_fifo #(
        .WIDTH (`SFP_FIFO_WIDTH),
        .DEPTH (`SFP_FIFO_DEPTH),
        .AW    (5)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (walk_hit),
        .in_ready  (fifo_rdy),
        .in_data   (fifo_din),
        .out_valid (mem_valid),
        .out_ready (mem_ready),
        .out_data  ({mem_addr, mem_data}),
        .idle      (fifo_idle)
    );
endmodule

`default_nettype wire

// File: dv/sfp_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none

// ==========
// Checker on status flags and array ports
module sfp_core_asserts #(
    parameter [31:0] SUS_CYC = 4
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Status
    input wire logic        busy,
    input wire logic        write_enable_latch,
    input wire logic        suspend_flag,
    // Array ports
    input wire logic        mem_valid,
    input wire logic        mem_ready,
    input wire logic [23:0] mem_addr,
    input wire logic [7:0]  mem_data,
    input wire logic        erase_valid,
    input wire logic [2:0]  erase_kind
);
    localparam int SUS_MAX = SUS_CYC + 3;
    logic ce_run;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Held to busy fall; resume gives no new erase pulse
    always @(posedge ref_clk) begin
        ce_run <= !rst_n ? 1'b0 : erase_valid ? (erase_kind == 3'h4) : ($fell(busy) ? 1'b0 : ce_run);
    end

    // Resume also raises busy, so those edges are left out
    chk_wel_cleared:
        assert property ($rose(busy) && !$past(suspend_flag) && !$past(suspend_flag, 2)
            |-> !write_enable_latch) else $error("latch set after cycle start");
    chk_start_latch:
        assert property ($rose(busy) && !$past(suspend_flag) && !$past(suspend_flag, 2)
            |-> $past(write_enable_latch)) else $error("cycle started without latch");
    chk_erase_busy:
        assert property (erase_valid |-> ##[0:1] busy) else $error("erase without busy");
    chk_sus_drop:
        assert property ($rose(suspend_flag) |-> ##[0:SUS_MAX] !busy)
        else $error("busy held after suspend");
    chk_sus_cause:
        assert property ($rose(suspend_flag) |-> $past(busy)) else $error("suspend while idle");
    chk_sus_chip:
        assert property ($rose(suspend_flag) |-> !ce_run) else $error("chip erase suspended");
    chk_resume_busy:
        assert property ($fell(suspend_flag) |-> ##[0:2] busy) else $error("no busy on resume");
    chk_sus_no_erase:
        assert property (suspend_flag |-> !erase_valid) else $error("erase while suspended");
    chk_mem_hold:
        assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr)
            && $stable(mem_data)) else $error("array byte dropped");
    chk_mem_busy:
        assert property (mem_valid |-> busy) else $error("array write while not busy");

    cover property ($rose(suspend_flag));
    cover property (erase_valid && erase_kind == 3'h4);
    cover property (mem_valid && !mem_ready);
endmodule

bind sfp_core sfp_core_asserts #(.SUS_CYC(SUS_CYC)) i_sfp_core_asserts (
    .ref_clk(ref_clk), .rst_n(rst_n), .busy(busy),
    .write_enable_latch(write_enable_latch), .suspend_flag(suspend_flag),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
    .mem_data(mem_data), .erase_valid(erase_valid), .erase_kind(erase_kind)
);

`default_nettype wire

// File: dv/sfp_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========
// Host side of the link, mode 0, sck stands low outside frames
module sfp_host_model (
    // Link pins
    output logic            sck,
    output logic            cs_n,
    output logic [3:0]      io_in,
    // Status return
    input  wire logic [3:0] io_out
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        io_in = 4'h0;
    end

    task automatic tick(input logic [3:0] v);
        io_in <= v;
        #400 sck <= 1'b1;
        #400 sck <= 1'b0;
    endtask

    // Unused lines toggle rather than hold
    task automatic sbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) tick({~io_in[3:1], b[i]});
    endtask

    task automatic qbyte(input logic [7:0] b);
        tick(b[7:4]);
        tick(b[3:0]);
    endtask

    task automatic cs_lo();
        #400 cs_n <= 1'b0;
        #400;
    endtask

    // Released lines show the inverse
    task automatic cs_hi();
        #400 cs_n <= 1'b1;
        io_in <= ~io_in;
        #1600;
    endtask

    // Sampled before the next fall
    task automatic rdsr(output logic [7:0] s);
        cs_lo();
        sbyte(8'h05);
        for (int i = 0; i < 8; i++) begin
            #400 sck <= 1'b1;
            #400 s = {s[6:0], io_out[1]};
            sck <= 1'b0;
        end
        cs_hi();
    endtask
endmodule

`default_nettype wire

// File: dv/sfp_core_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfp_defines.vh"

module sfp_core_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        quad_enable_bit = 1'b0;
    logic        mem_ready = 1'b0;
    logic        stall = 1'b1;
    localparam [31:0] T_PP = 100, T_SE = 400, T_B32 = 450, T_B64 = 500, SUSPEND_LATENCY = 4;
    wire         sck, cs_n, busy, write_enable_latch, suspend_flag, mem_valid, erase_valid;
    wire [3:0]   io_in, io_out, io_oe;
    wire [23:0]  mem_addr, erase_addr;
    wire [7:0]   mem_data;
    wire [2:0]   erase_kind;
    int          fail_count = 0;
    int          check_count = 0;
    int          ne = 0;
    logic [2:0]  ek;
    logic [23:0] ea;
    logic [7:0]  st;
    logic [23:0] got_a[$];
    logic [7:0]  got_d[$];
    // Opcode, kind, address
    logic [39:0] rows[5] = '{40'h20_01_012345, 40'h52_02_0a8000, 40'hd8_03_3f0000,
                             40'hc7_04_000000, 40'h60_04_000000};

    always #50 ref_clk = ~ref_clk;

    sfp_core #(.PP_CYC(T_PP), .SE_CYC(T_SE), .BE32_CYC(T_B32), .BE64_CYC(T_B64), .CE_CYC(T_SE),
        .SUS_CYC(SUSPEND_LATENCY)) i_sfp_core (.*);

    sfp_host_model i_sfp_host_model (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));

    // ==========
    // Array side: stallable sink
    always @(posedge ref_clk) begin
        mem_ready <= !stall;
        if (mem_valid && mem_ready) begin
            got_a.push_back(mem_addr);
            got_d.push_back(mem_data);
        end
        if (erase_valid) begin
            ek <= erase_kind;
            ea <= erase_addr;
            ne <= ne + 1;
        end
    end

    // ==========
    // Tasks
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Bit 8 flips bit 7 so overwritten bytes differ
    function automatic logic [7:0] pat(input int i);
        return i[7:0] ^ {i[8], 7'h2d};
    endfunction

    task automatic send(input logic [7:0] op, input logic [23:0] a, input int nad,
                        input int nd, input logic q, input int xb);
        logic [7:0] b;
        i_sfp_host_model.cs_lo();
        i_sfp_host_model.sbyte(op);
        for (int i = 0; i < nad + nd; i++) begin
            b = i < nad ? a[23 - 8 * i -: 8] : pat(i - nad);
            if (q) i_sfp_host_model.qbyte(b);
            else i_sfp_host_model.sbyte(b);
        end
        repeat (xb) i_sfp_host_model.tick(4'h1);
        i_sfp_host_model.cs_hi();
    endtask

    task automatic op1(input logic [7:0] op);
        send(op, 24'h0, 0, 0, 1'b0, 0);
    endtask

    task automatic idle();
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge ref_clk);
        chk(busy, 1'b0, "busy end");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========
    // Sequence
    initial begin
        int k;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge ref_clk);
        chk({busy, write_enable_latch, suspend_flag}, 3'h0, "reset");
        send(`SFP_OP_SE, 24'h001000, 3, 0, 1'b0, 0);
        chk({busy, ne}, 33'h0, "no latch");
        for (int r = 0; r < 5; r++) begin
            op1(`SFP_OP_WRITE_ENABLE_CMD);
            chk(write_enable_latch, 1'b1, "latch");
            send(rows[r][39:32], rows[r][23:0], rows[r][26:24] == 3'h4 ? 0 : 3, 0, 1'b0, 0);
            i_sfp_host_model.rdsr(st);
            chk(st, 8'h01, "status");
            chk(io_oe, 4'h0, "oe off");
            idle();
            chk({ne, ek, ea}, {r + 1, rows[r][26:0]}, "erase");
        end
        op1(`SFP_OP_WRITE_ENABLE_CMD);
        send(`SFP_OP_SE, 24'h002000, 3, 0, 1'b0, 4);
        chk({busy, ne}, 33'd5, "torn cs");
        op1(`SFP_OP_WRITE_ENABLE_CMD);
        send(`SFP_OP_PP, 24'h0102fe, 3, 258, 1'b0, 0);
        chk(busy, 1'b1, "stalled busy");
        @(posedge ref_clk) stall <= 1'b0;
        idle();
        chk(got_a.size(), 256, "page count");
        for (int c = 0; c < 256; c++) begin
            k = (c + 2) % 256;
            k = k < 2 ? k + 256 : k;
            chk({got_a[c], got_d[c]}, {16'h0102, c[7:0], pat(k)}, "page byte");
        end
        got_a.delete();
        got_d.delete();
        op1(`SFP_OP_WRITE_ENABLE_CMD);
        send(`SFP_OP_QPP, 24'h0000fe, 3, 3, 1'b1, 0);
        chk(busy, 1'b0, "quad off");
        @(posedge ref_clk) quad_enable_bit <= 1'b1;
        op1(`SFP_OP_WRITE_ENABLE_CMD);
        send(`SFP_OP_QPP, 24'h0000fe, 3, 3, 1'b1, 0);
        idle();
        chk({got_a.size(), got_a[0], got_a[1], got_a[2]}, {32'd3, 24'h0, 24'hfe, 24'hff},
            "quad cols");
        chk({got_d[0], got_d[1], got_d[2]}, {pat(2), pat(0), pat(1)}, "quad data");
        op1(`SFP_OP_SUSP);
        chk(suspend_flag, 1'b0, "idle suspend");
        op1(`SFP_OP_WRITE_ENABLE_CMD);
        send(`SFP_OP_SE, 24'h004000, 3, 0, 1'b0, 0);
        op1(`SFP_OP_SUSP);
        chk({suspend_flag, busy}, 2'h2, "suspend");
        op1(`SFP_OP_WRITE_ENABLE_CMD);
        send(`SFP_OP_PP, 24'h000100, 3, 1, 1'b0, 0);
        send(`SFP_OP_BE64, 24'h010000, 3, 0, 1'b0, 0);
        chk({busy, ne, got_a.size()}, {1'b0, 32'd6, 32'd3}, "refused");
        op1(`SFP_OP_RESM);
        chk({suspend_flag, busy, ne}, {2'h1, 32'd6}, "resume");
        idle();
        op1(`SFP_OP_WRITE_ENABLE_CMD);
        op1(`SFP_OP_CE1);
        op1(`SFP_OP_SUSP);
        chk({suspend_flag, busy}, 2'h1, "chip suspend");
        idle();
        op1(`SFP_OP_WRITE_ENABLE_CMD);
        send(`SFP_OP_BE32, 24'h008000, 3, 0, 1'b0, 0);
        op1(`SFP_OP_SUSP);
        @(posedge ref_clk) rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk({suspend_flag, busy}, 2'h0, "power loss");
        conclude();
    end

    // Whole run is near 2.5 ms
    initial begin
        #8_000_000;
        fail_count++;
        conclude();
    end
endmodule

`default_nettype wire
